// File: hw/seep_pkg.sv
// Package for the serial EEPROM command and protection front end.
// Assumes a single system clock; all link pins are sampled and synchronised inside the block.
package seep_pkg;
	localparam int unsigned ADDR_W      = 16;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned PAGE_BYTES  = 128;
	localparam int unsigned FIFO_DEPTH  = 8;
	localparam int unsigned CLK_MHZ     = 25;
	// Internal write cycle time in microseconds and its cycle count
	localparam int unsigned WRITE_US    = 10000;
	localparam int unsigned WRITE_CYC   = WRITE_US * CLK_MHZ;
	// Opcode decode: upper nibble zero, bit 3 ignored, low three bits select
	localparam logic [3:0] OP_HI        = 4'h0;
	localparam logic [2:0] OP_SET_WL    = 3'h6;
	localparam logic [2:0] OP_CLR_WL    = 3'h4;
	localparam logic [2:0] OP_RD_STAT   = 3'h5;
	localparam logic [2:0] OP_WR_STAT   = 3'h1;
	localparam logic [2:0] OP_RD_ARRAY  = 3'h3;
	localparam logic [2:0] OP_WR_ARRAY  = 3'h2;
	// Status register field positions
	localparam int unsigned ST_PPE      = 7;
	localparam int unsigned ST_BPH      = 3;
	localparam int unsigned ST_BPL      = 2;
	localparam int unsigned ST_WL       = 1;
	localparam int unsigned ST_BUSY     = 0;
	localparam logic [7:0] ST_BUSY_VAL  = 8'hff;
	localparam logic [7:0] ST_WR_MASK   = 8'h8c;
	// Protection levels (block protect codes) and top quarter upper address bits
	localparam logic [1:0] BP_NONE      = 2'h0;
	localparam logic [1:0] BP_QUARTER   = 2'h1;
	localparam logic [1:0] BP_HALF      = 2'h2;
	localparam logic [1:0] QTR_TOP      = 2'h3;

	typedef enum logic [2:0] {
		SEEP_OPCODE,
		SEEP_ADDR,
		SEEP_RX_DATA,
		SEEP_TX_DATA,
		SEEP_DEAD
	} seep_state_type;

	// One byte handed from the link to the array write path
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} seep_wr_type;

	// Sampled link pins
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic si;
		logic pause_n;
		logic wp_n;
	} seep_pins_type;
endpackage

// File: hw/seep_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; write and read may occur in the same cycle.
`timescale 1ns/10ps
module seep_fifo #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             sys_clk_i,  // System clock
	input  wire logic             rst_i,      // Sync reset
	input  wire logic             flush_i,    // Drop contents
	input  wire logic             in_valid_i, // Write request
	output logic                  in_ready_o, // Space free
	input  wire logic [WIDTH-1:0] in_data_i,  // Write word
	output logic                  out_valid_o,// Word available
	input  wire logic             out_ready_i,// Consumer takes word
	output logic      [WIDTH-1:0] out_data_o  // Head word
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Honest flags from the occupancy count
	assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rd_q];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	// Pointers and count
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || flush_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // seep_fifo

// File: hw/seep_core.sv
// Serial EEPROM slave front end: opcode decode, status register, protection, array access.
// Assumes the link pins are asynchronous to sys_clk_i and the serial clock is far slower.
`timescale 1ns/10ps
// Contract
// - Device is slave only; serial clock always comes in from host.
// - First byte after select is the opcode, held in eight-bit register.
// - Unknown opcode: ignore input, keep output off until next select.
// - Deselected: ignore serial input, output stays off.
// - Pause pin low with clock low freezes sequence; high with clock low resumes.
// - While paused, output off and serial input ignored.
// - Protect pin low with pin enable set blocks status writes.
// - Protect pin falling during select aborts status write; later no effect.
// - Pin enable clear makes protect pin ignored.
// - All bytes move most significant bit first.
// - Decode set latch, clear latch, status read ignoring bit three.
// - Decode status write, array read, array write ignoring bit three.
// - Status layout: pin enable 7, protect 3 and 2, latch 1, busy 0.
// - Write latch is clear after reset.
// - Clear latch opcode disables programming regardless of protect pin.
// - Pin enable cannot return to zero while protection active.
// - Status writable only with latch set and hardware protection off.
// - Block protect bits guard none, top quarter, top half, or all.
// - Array read ignores input after address and shifts data out.
// - Read address increments while selected and wraps at the top.
// - Busy bit reads one during internal write cycle.
// - Status read gives zero bits six-four idle, all ones when busy.
// - During internal write only status read is obeyed.
// - Programming starts when select rises after a complete byte.
// - Page write takes up to 128 bytes, wrapping low eight address bits (the FIFO stages only the first 8 bytes).
// - Write latch clears at end of each internal write cycle.
module seep_core
	import seep_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = WRITE_CYC
) (
	input  wire logic sys_clk_i,     // System clock, 25 MHz
	input  wire logic rst_i,         // Sync reset, active high
	input  wire logic sck_i,         // Serial clock from host
	input  wire logic chip_select_n_i,  // Select, active low
	input  wire logic serial_in_i,   // Serial data in
	input  wire logic pause_n_i,     // Pause, active low
	input  wire logic write_protect_pin_n_i, // Protect pin, active low
	output logic      serial_out_o,  // Serial data out
	output logic      serial_out_oe_n_o, // Output enable, low drives
	output logic      busy_o         // Internal write cycle running
);
	seep_pins_type    s1_q, s2_q;   // Two-stage synchroniser
	logic             sck_prev_q;
	logic             cs_prev_q;
	logic             wp_prev_q;
	logic             paused_q;
	seep_state_type   state_q;
	logic [7:0]       shift_q;
	logic [2:0]       bit_q;
	logic             addr_lo_q;
	logic [7:0]       opcode_q;
	logic [15:0]      addr_q;
	logic [7:0]       status_q;      // Stored bits 7,3,2,1
	logic [7:0]       tx_q;
	logic             oe_q;
	logic             wr_stat_pend_q;
	logic             wp_abort_q;    // Protect pin fell during this select
	logic             wp_fall_sel;
	logic [7:0]       wr_stat_val_q;
	logic             wr_arr_pend_q;
	logic             byte_full_q;   // Last byte ended on a boundary
	logic [31:0]      wcnt_q;
	logic             busy_q;
	logic [7:0]       mem_q [2**ADDR_W];
	logic             sck_rise, sck_fall, cs_fall, cs_rise, active;
	logic [7:0]       rx_byte;
	logic             byte_done;
	logic             hw_prot;
	logic             fifo_in_ready, fifo_out_valid, fifo_out_ready;
	seep_wr_type      fifo_in, fifo_out;
	logic [7:0]       status_rd;

	// Opcode decoder shared by decode and illegal check
	function automatic logic op_is(input logic [7:0] op, input logic [2:0] code);
		return (op[7:4] == OP_HI) && (op[2:0] == code);
	endfunction

	function automatic logic op_valid(input logic [7:0] op);
		return (op[7:4] == OP_HI) && (op[2:0] != 3'h0) && (op[2:0] != 3'h7);
	endfunction

	// Address guarded by the block protect level
	function automatic logic addr_protected(input logic [1:0] bp, input logic [15:0] a);
		unique case (bp)
			BP_NONE:    return 1'b0;
			BP_QUARTER: return a[15:14] == QTR_TOP;
			BP_HALF:    return a[15];
			default:    return 1'b1;
		endcase
	endfunction

	// Pins are asynchronous: two flops before use; the serial clock is only ever sampled
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s1_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, pause_n: 1'b1, wp_n: 1'b1};
			s2_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, pause_n: 1'b1, wp_n: 1'b1};
		end else begin
			s1_q <= '{sck: sck_i, cs_n: chip_select_n_i, si: serial_in_i,
			          pause_n: pause_n_i, wp_n: write_protect_pin_n_i};
			s2_q <= s1_q;
		end
	end

	// Edge history on the synchronised pins
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sck_prev_q <= 1'b0;
			cs_prev_q  <= 1'b1;
			wp_prev_q  <= 1'b1;
		end else begin
			sck_prev_q <= s2_q.sck;
			cs_prev_q  <= s2_q.cs_n;
			wp_prev_q  <= s2_q.wp_n;
		end
	end

	assign sck_rise  = s2_q.sck && !sck_prev_q;
	assign sck_fall  = !s2_q.sck && sck_prev_q;
	assign cs_fall   = !s2_q.cs_n && cs_prev_q;
	assign cs_rise   = s2_q.cs_n && !cs_prev_q;
	assign active    = !s2_q.cs_n && !paused_q;
	assign rx_byte   = {shift_q[6:0], s2_q.si};
	assign byte_done = active && sck_rise && (bit_q == 3'h7);
	assign hw_prot   = !s2_q.wp_n && status_q[ST_PPE];

	// Pause only changes while the serial clock is low, except that deselect clears it
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || s2_q.cs_n) begin
			paused_q <= 1'b0;
		end else if (!s2_q.sck) begin
			paused_q <= !s2_q.pause_n;
		end
	end

	// Bit counter and input shifter
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || s2_q.cs_n) begin
			bit_q   <= 3'h0;
			shift_q <= 8'h00;
		end else if (active && sck_rise && state_q != SEEP_DEAD) begin
			bit_q   <= bit_q + 3'h1;
			shift_q <= rx_byte;
		end
	end

	// Sequence state: opcode, address bytes, then data in or out
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || cs_fall) begin
			state_q   <= SEEP_OPCODE;
			opcode_q  <= 8'h00;
			addr_lo_q <= 1'b0;
		end else if (byte_done) begin
			unique case (state_q)
				SEEP_OPCODE: begin
					opcode_q <= rx_byte;
					if (!op_valid(rx_byte) || (busy_q && !op_is(rx_byte, OP_RD_STAT))) begin
						state_q <= SEEP_DEAD;
					end else if (op_is(rx_byte, OP_RD_ARRAY) || op_is(rx_byte, OP_WR_ARRAY)) begin
						state_q <= SEEP_ADDR;
					end else if (op_is(rx_byte, OP_RD_STAT)) begin
						state_q <= SEEP_TX_DATA;
					end else if (op_is(rx_byte, OP_WR_STAT)) begin
						state_q <= SEEP_RX_DATA;
					end else begin
						state_q <= SEEP_DEAD;
					end
				end
				SEEP_ADDR: begin
					addr_lo_q <= 1'b1;
					if (addr_lo_q) begin
						state_q <= op_is(opcode_q, OP_RD_ARRAY) ? SEEP_TX_DATA : SEEP_RX_DATA;
					end
				end
				SEEP_RX_DATA, SEEP_TX_DATA, SEEP_DEAD: begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// Address register: loaded MSB byte first, increments per data byte
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			addr_q <= 16'h0000;
		end else if (byte_done && state_q == SEEP_ADDR) begin
			addr_q <= {addr_q[7:0], rx_byte};
		end else if (byte_done && state_q == SEEP_TX_DATA && op_is(opcode_q, OP_RD_ARRAY)) begin
			addr_q <= addr_q + 16'h0001;
		end else if (byte_done && state_q == SEEP_RX_DATA && op_is(opcode_q, OP_WR_ARRAY)) begin
			addr_q <= {addr_q[15:8], addr_q[7:0] + 8'h01};
		end
	end

	// Byte boundary tracking so a late select rise commits nothing
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || cs_fall) begin
			byte_full_q <= 1'b0;
		end else if (active && sck_rise) begin
			byte_full_q <= (bit_q == 3'h7);
		end
	end

	// A protect pin fall anywhere in the select spoils it, even before the data byte is in
	assign wp_fall_sel = !s2_q.cs_n && wp_prev_q && !s2_q.wp_n && status_q[ST_PPE];
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || cs_fall) begin
			wp_abort_q <= 1'b0;
		end else if (wp_fall_sel) begin
			wp_abort_q <= 1'b1;
		end
	end

	// Status write staged until select rises; a falling protect pin aborts it
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || cs_fall) begin
			wr_stat_pend_q <= 1'b0;
			wr_stat_val_q  <= 8'h00;
		end else if (byte_done && state_q == SEEP_RX_DATA && op_is(opcode_q, OP_WR_STAT)) begin
			wr_stat_pend_q <= !(wp_abort_q || wp_fall_sel);
			wr_stat_val_q  <= rx_byte;
		end else if (wp_fall_sel) begin
			wr_stat_pend_q <= 1'b0;
		end
	end

	// Page bytes go through the FIFO; a full FIFO keeps the earlier bytes only
	assign fifo_in = '{addr: addr_q, data: rx_byte};
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || cs_fall) begin
			wr_arr_pend_q <= 1'b0;
		end else if (byte_done && state_q == SEEP_RX_DATA && op_is(opcode_q, OP_WR_ARRAY)
		             && status_q[ST_WL] && !addr_protected(status_q[ST_BPH:ST_BPL], addr_q)) begin
			wr_arr_pend_q <= 1'b1;
		end
	end

	seep_fifo #(.WIDTH($bits(seep_wr_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk_i  (sys_clk_i),
		.rst_i      (rst_i),
		.flush_i    (cs_fall && !busy_q),
		.in_valid_i (byte_done && state_q == SEEP_RX_DATA && op_is(opcode_q, OP_WR_ARRAY)
		             && status_q[ST_WL] && !addr_protected(status_q[ST_BPH:ST_BPL], addr_q)),
		.in_ready_o (fifo_in_ready),
		.in_data_i  (fifo_in),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o (fifo_out)
	);
	// Drain only during the internal write cycle, so the FIFO really fills meanwhile
	assign fifo_out_ready = busy_q;

	// Array storage; programming drains staged bytes
	always_ff @(posedge sys_clk_i) begin
		if (fifo_out_valid && fifo_out_ready) begin
			mem_q[fifo_out.addr] <= fifo_out.data;
		end
	end

	// Internal write cycle timer, started by select rising on a byte boundary
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
			wcnt_q <= 32'h0;
		end else if (!busy_q && cs_rise && byte_full_q && (wr_arr_pend_q || (wr_stat_pend_q
		             && status_q[ST_WL] && !hw_prot))) begin
			busy_q <= 1'b1;
			wcnt_q <= WRITE_CYCLES - 32'h1;
		end else if (busy_q && wcnt_q != 32'h0) begin
			wcnt_q <= wcnt_q - 32'h1;
		end else if (busy_q) begin
			busy_q <= 1'b0;
		end
	end

	// Status bits: latch set/clear, protection fields committed at write start
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			status_q <= 8'h00;
		end else if (busy_q && wcnt_q == 32'h0) begin
			status_q[ST_WL] <= 1'b0;
		end else if (!busy_q && cs_rise && byte_full_q && wr_stat_pend_q && status_q[ST_WL] && !hw_prot) begin
			status_q[ST_BPH] <= wr_stat_val_q[ST_BPH];
			status_q[ST_BPL] <= wr_stat_val_q[ST_BPL];
			status_q[ST_PPE] <= wr_stat_val_q[ST_PPE] | hw_prot;
		end else if (byte_done && state_q == SEEP_OPCODE && !busy_q && op_is(rx_byte, OP_SET_WL)) begin
			status_q[ST_WL] <= 1'b1;
		end else if (byte_done && state_q == SEEP_OPCODE && !busy_q && op_is(rx_byte, OP_CLR_WL)) begin
			status_q[ST_WL] <= 1'b0;
		end
	end

	// Status as read: all ones while busy
	assign status_rd = busy_q ? ST_BUSY_VAL : (status_q & ST_WR_MASK) | {6'h00, status_q[ST_WL], 1'b0};

	// Output shifter loads on the serial clock rise that ends a byte, shifts on serial clock fall, MSB first
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || s2_q.cs_n) begin
			tx_q <= 8'h00;
			oe_q <= 1'b0;
		end else if (byte_done && ((state_q == SEEP_OPCODE && op_is(rx_byte, OP_RD_STAT) && op_valid(rx_byte))
		             || (state_q == SEEP_ADDR && addr_lo_q && op_is(opcode_q, OP_RD_ARRAY))
		             || state_q == SEEP_TX_DATA)) begin
			tx_q <= (op_is(opcode_q, OP_RD_ARRAY) || state_q == SEEP_ADDR)
			        ? mem_q[(state_q == SEEP_ADDR) ? {addr_q[7:0], rx_byte} : addr_q + 16'h0001]
			        : status_rd;
			oe_q <= 1'b1;
		end else if (active && sck_fall && oe_q && bit_q != 3'h0) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	assign serial_out_o      = tx_q[7];
	assign serial_out_oe_n_o = !(oe_q && active && state_q != SEEP_DEAD);
	assign busy_o            = busy_q;

	// Checks
	AST_DESELECT_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s2_q.cs_n |-> serial_out_oe_n_o) else $error("Output driven while deselected");
	AST_PAUSE_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		paused_q |-> serial_out_oe_n_o) else $error("Output driven while paused");
	AST_BAD_OP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(byte_done && state_q == SEEP_OPCODE && !op_valid(rx_byte)) |=> state_q == SEEP_DEAD)
		else $error("Illegal opcode not locked out");
	AST_BUSY_ALLONES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(byte_done && state_q == SEEP_OPCODE && op_is(rx_byte, OP_RD_STAT) && busy_q) |=> tx_q == 8'hff)
		else $error("Busy status not all ones");
	AST_IDLE_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(byte_done && state_q == SEEP_OPCODE && op_is(rx_byte, OP_RD_STAT) && !busy_q)
		|=> tx_q[6:4] == 3'h0 && !tx_q[0]) else $error("Idle status bits wrong");
	AST_PPE_STICKY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		hw_prot && $stable(s2_q.wp_n) |=> status_q[ST_PPE]) else $error("Pin enable cleared under protection");
	AST_WL_CLEAR_END: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$fell(busy_q) |-> !status_q[ST_WL]) else $error("Latch not cleared after write");
	AST_CLR_WL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(byte_done && state_q == SEEP_OPCODE && !busy_q && op_is(rx_byte, OP_CLR_WL)) |=> !status_q[ST_WL])
		else $error("Clear latch opcode ignored");
	AST_BUSY_STATE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(byte_done && state_q == SEEP_OPCODE && busy_q && !op_is(rx_byte, OP_RD_STAT)) |=> state_q == SEEP_DEAD)
		else $error("Opcode obeyed while busy");
	COV_STAT_READ: cover property (@(posedge sys_clk_i) byte_done && state_q == SEEP_OPCODE && op_is(rx_byte, OP_RD_STAT));
	COV_ARR_READ: cover property (@(posedge sys_clk_i) state_q == SEEP_TX_DATA && op_is(opcode_q, OP_RD_ARRAY));
	COV_WRITE: cover property (@(posedge sys_clk_i) $rose(busy_q));
	COV_PAUSE: cover property (@(posedge sys_clk_i) $rose(paused_q));
endmodule // seep_core

// File: dv/seep_host_model.sv
// Behavioural SPI host in mode 0 for the serial EEPROM front end.
// Assumes sys_clk_i at 25 MHz; each serial clock phase is four system clocks (320 ns period).
`timescale 1ns/10ps
module seep_host_model (
	input  wire logic sys_clk_i, // System clock
	input  wire logic so_i,      // Resolved serial out line
	input  wire logic oe_n_i,    // Device output enable, low drives
	output logic      sck_o,     // Serial clock, still between frames
	output logic      cs_n_o,    // Select, active low
	output logic      si_o,      // Serial data to device
	output logic      pause_n_o  // Pause, active low
);
	int pause_at = -1; // Bit index preceded by a pause, -1 for none
	int oe_bad   = 0;  // Times the device drove while paused
	// Idle levels; the host alone makes the serial clock
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		pause_n_o = 1'b1;
	end
	// Data line wanders outside frames so a deselected device cannot lean on it
	always @(posedge sys_clk_i) if (cs_n_o) si_o <= ~si_o;
	// One serial clock phase
	task automatic half();
		repeat (4) @(posedge sys_clk_i);
	endtask
	// Pause with the clock low, keep toggling clock and data, resume with the clock low
	task automatic hold();
		pause_n_o <= 1'b0;
		repeat (2) begin
			half();
			sck_o <= 1'b1;
			si_o <= ~si_o;
			half();
			if (oe_n_i !== 1'b1) oe_bad++;
			sck_o <= 1'b0;
		end
		pause_n_o <= 1'b1;
	endtask
	// Sends tx (opcode first), then clocks nrd bytes back, sampled mid-way through the high phase
	task automatic frame(input logic [7:0] tx[$], input int nrd, output logic [7:0] rx[$]);
		logic [7:0] b;
		rx = {};
		half();
		cs_n_o <= 1'b0;
		half();
		for (int i = 0; i < tx.size() + nrd; i++) begin
			b = (i < tx.size()) ? tx[i] : 8'($urandom); // Junk while the device talks
			for (int k = 7; k >= 0; k--) begin
				if (pause_at == i * 8 + 7 - k) hold();
				si_o <= b[k];
				half();
				sck_o <= 1'b1;
				repeat (2) @(posedge sys_clk_i);
				b[k] = so_i; // Taken mid-high: the next byte reloads late in the high phase
				repeat (2) @(posedge sys_clk_i);
				sck_o <= 1'b0;
			end
			if (i >= tx.size()) rx.push_back(b);
		end
		half();
		cs_n_o <= 1'b1; // Rises in clock-low time after a whole byte
		repeat (2) half();
	endtask
endmodule // seep_host_model

// File: dv/seep_core_tb.sv
// Self-checking bench for the serial EEPROM front end and its staging FIFO.
// Assumes seep_host_model as the SPI host and a shortened internal write cycle.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module seep_core_tb;
	import seep_pkg::*;
	localparam int unsigned WCYC = 600; // Long enough to probe the busy state twice
	logic             sys_clk_i;
	logic             rst_i;
	logic             wp_n;
	logic             so_last;
	logic       [7:0] pg[$];
	logic       [7:0] s;
	logic       [7:0] st_m;
	logic      [15:0] a;
	logic      [15:0] lo;
	logic       [7:0] rx[$];
	logic       [7:0] mem[logic [15:0]];
	logic       [7:0] bad[4] = '{8'h07, 8'h08, 8'h85, 8'h1b};
	logic       [9:0] hw[6]  = '{10'h280, 10'h00c, 10'h284, 10'h380, 10'h200, 10'h008};
	int               miscompares = 0;
	int               tests_run = 0;
	int               oe_low = 0;
	wire logic        sck, cs_n, si, pause_n, so, oe_n, busy, so_line;
	// Released output line shows the inverse of its last level, never a kind guess
	assign so_line = oe_n ? ~so_last : so;
	always @(posedge sys_clk_i) if (!oe_n) so_last <= so;
	always @(posedge sys_clk_i) if (oe_n === 1'b0) oe_low++;
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	seep_core #(.WRITE_CYCLES(WCYC)) seep_core_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sck_i(sck),
		.chip_select_n_i(cs_n), .serial_in_i(si), .pause_n_i(pause_n), .write_protect_pin_n_i(wp_n),
		.serial_out_o(so), .serial_out_oe_n_o(oe_n), .busy_o(busy));
	seep_host_model seep_host_model_inst (.sys_clk_i(sys_clk_i), .so_i(so_line), .oe_n_i(oe_n), .sck_o(sck),
		.cs_n_o(cs_n), .si_o(si), .pause_n_o(pause_n));
	// Opcode with a random don't-care bit 3
	function automatic logic [7:0] opc(input logic [2:0] c);
		return {OP_HI, 1'($urandom), c};
	endfunction
	function automatic logic prot(input logic [1:0] bp, input logic [15:0] x);
		return (bp == BP_QUARTER && x[15:14] == QTR_TOP) || (bp == BP_HALF && x[15]) || bp == 2'h3;
	endfunction
	task automatic cmd(input logic [2:0] c);
		seep_host_model_inst.frame({opc(c)}, 0, rx);
	endtask
	task automatic rd_stat(output logic [7:0] v);
		seep_host_model_inst.frame({opc(OP_RD_STAT)}, 1, rx);
		v = rx[0];
		`CHK(oe_n, 1'b1);
	endtask
	// Status write; drop pulses the protect pin low in mid-frame
	task automatic wr_stat(input logic [7:0] v, input logic drop);
		cmd(OP_SET_WL);
		fork
			seep_host_model_inst.frame({opc(OP_WR_STAT), v}, 0, rx);
			if (drop) begin
				repeat (60) @(posedge sys_clk_i);
				wp_n <= 1'b0;
				repeat (20) @(posedge sys_clk_i);
				wp_n <= 1'b1;
			end
		join
		if (!drop && (wp_n || !st_m[ST_PPE])) st_m = v & ST_WR_MASK;
		// A committed status write runs an internal write cycle, so poll it out
		s = 8'h01;
		for (int n = 0; n < 10 && s[ST_BUSY]; n++) rd_stat(s);
		`CHK(s[ST_BUSY], 1'b0);
		`CHK(s & ST_WR_MASK, st_m);
	endtask
	// Array write, then busy probing and polling until ready
	task automatic wr_arr(input logic [15:0] a, input logic [7:0] d[$]);
		logic [15:0] x;
		int          nb;
		nb = 0;
		cmd(OP_SET_WL);
		seep_host_model_inst.frame({opc(OP_WR_ARRAY), a[15:8], a[7:0], d}, 0, rx);
		foreach (d[i]) begin
			x = {a[15:8], a[7:0] + 8'(i)}; // Only the low byte steps
			if (!prot(st_m[3:2], x) && nb < FIFO_DEPTH) begin // Staging holds only the first bytes
				mem[x] = d[i];
				nb++;
			end
		end
		if (nb != 0) begin
			rd_stat(s);
			`CHK(s, ST_BUSY_VAL);
			`CHK(busy, 1'b1);
			oe_low = 0;
			seep_host_model_inst.frame({opc(OP_RD_ARRAY), 8'h00, 8'h00}, 1, rx);
			`CHK(oe_low, 0);
		end
		s = 8'h01;
		for (int n = 0; n < 10 && s[ST_BUSY]; n++) rd_stat(s);
		`CHK(s[ST_BUSY], 1'b0);
		`CHK(s[ST_WL], 1'(nb == 0));
	endtask
	task automatic chk_rd(input logic [15:0] a, input int n);
		seep_host_model_inst.frame({opc(OP_RD_ARRAY), a[15:8], a[7:0]}, n, rx);
		foreach (rx[i]) `CHK(rx[i], mem[a + 16'(i)]);
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(97645));
		rst_i = 1'b1;
		wp_n = 1'b1;
		st_m = 8'h00;
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rd_stat(s);
		`CHK(s, 8'h00);
		cmd(OP_SET_WL);
		rd_stat(s);
		`CHK(s, 8'h02);
		wp_n <= 1'b0;
		cmd(OP_CLR_WL);
		rd_stat(s);
		`CHK(s, 8'h00);
		wp_n <= 1'b1;
		$display("latch test done");
		wr_arr(16'h0000, {8'($urandom)});
		wr_arr(16'hfffe, {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)});
		chk_rd(16'hfffe, 3);
		chk_rd(16'hff00, 2);
		repeat (4) begin
			a = 16'($urandom);
			wr_arr(a, {8'($urandom), 8'($urandom)});
			chk_rd(a, 1);
		end
		$display("array test done");
		// Each level: prime both sides of its boundary, protect, overwrite, read back
		for (int b = 1; b < 4; b++) begin
			lo = (b == 3) ? 16'h4000 : (b == 2) ? 16'h7fff : 16'hbfff;
			wr_stat(8'h00, 1'b0);
			for (int k = 0; k < 4; k++) begin
				if (k == 2) wr_stat({4'h0, 2'(b), 2'h0}, 1'b0);
				wr_arr(k[0] ? ((b == 3) ? 16'h0000 : lo + 16'h0001) : lo, {8'($urandom)});
			end
			chk_rd(lo, (b == 3) ? 1 : 2);
			chk_rd(16'h0000, 1);
		end
		$display("block protect test done");
		foreach (hw[i]) begin
			wp_n <= hw[i][9];
			wr_stat(hw[i][7:0], hw[i][8]);
		end
		wp_n <= 1'b1;
		$display("pin protect test done");
		foreach (bad[i]) begin
			oe_low = 0;
			seep_host_model_inst.frame({bad[i]}, 2, rx);
			`CHK(oe_low, 0);
		end
		$display("invalid opcode test done");
		for (int p = 3; p < 16; p += 9) begin
			seep_host_model_inst.pause_at = p;
			rd_stat(s);
			`CHK(s & ST_WR_MASK, st_m);
			`CHK(seep_host_model_inst.oe_bad, 0);
		end
		seep_host_model_inst.pause_at = -1;
		$display("pause test done");
		// Page longer than the staging FIFO: the two bytes that wrap onto 1200 are refused
		wr_arr(16'h1200, {8'h5a, 8'ha5});
		repeat (10) pg.push_back(8'($urandom));
		wr_arr(16'h12f8, pg);
		`CHK(s & ST_WR_MASK, st_m);
		chk_rd(16'h12f8, 8);
		chk_rd(16'h1200, 2);
		`CHK(rx[0], 8'h5a);
		`CHK(rx[1], 8'ha5);
		$display("fifo test done");
		finish_test();
	end
	// Run needs about 40000 cycles
	initial begin
		repeat (80000) @(posedge sys_clk_i);
		miscompares++;
		$display("ERROR %0t: timeout", $time);
		finish_test();
	end
endmodule // seep_core_tb
